//--- include/drive_state_map.svh
`ifndef DRIVE_STATE_MAP_SVH
`define DRIVE_STATE_MAP_SVH

// Parameter address of the panel lock setting
`define PANEL_LOCK_ADDR      16'h3A02
`define PANEL_LOCK_RESET     16'h0000
`define PANEL_LOCK_OFF       16'h0000
`define PANEL_LOCK_ON        16'h0001

// Speed threshold between states 3 and 4, in 1/min
`define SPEED_LIMIT_RPM      16'h03E8

// Clock cycles from brake close command to amplifier off
`define BRAKE_DELAY_CYCLES   16

// Reported state numbers
`define ST_NUM_START         4'h1
`define ST_NUM_NOT_READY     4'h2
`define ST_NUM_DISABLED      4'h3
`define ST_NUM_READY         4'h4
`define ST_NUM_SWITCHED_ON   4'h5
`define ST_NUM_OP_ENABLE     4'h6
`define ST_NUM_QUICK_STOP    4'h7
`define ST_NUM_FAULT_REACT   4'h8
`define ST_NUM_FAULT         4'h9

// Stored error class codes
`define ERR_NONE             3'h0
`define ERR_CLASS_1          3'h1
`define ERR_CLASS_2          3'h2
`define ERR_CLASS_34         3'h3
`define ERR_POWER_REMOVED    3'h4

`endif

//--- include/drive_state_pkg.sv
package drive_state_pkg;

    typedef enum logic [8:0] {
        ST_START       = 9'b000000001,
        ST_NOT_READY   = 9'b000000010,
        ST_DISABLED    = 9'b000000100,
        ST_READY       = 9'b000001000,
        ST_SWITCHED_ON = 9'b000010000,
        ST_OP_ENABLE   = 9'b000100000,
        ST_QUICK_STOP  = 9'b001000000,
        ST_FAULT_REACT = 9'b010000000,
        ST_FAULT       = 9'b100000000
    } op_state_e;

    typedef enum logic [3:0] {
        RX_IDLE  = 4'b0001,
        RX_STOP  = 4'b0010,
        RX_BRAKE = 4'b0100,
        RX_OFF   = 4'b1000
    } react_e;

    typedef logic [2:0] err_class_t;

endpackage

//--- rtl/input_sync_edge.sv
module input_sync_edge #(
    parameter int W = 3
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] level,
    output logic      [W-1:0] rise,
    output logic      [W-1:0] fall
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] sync;
        logic [W-1:0] prev;
    } sync_s;

    sync_s st_reg;
    sync_s st_next;

    always_comb begin
        st_next      = st_reg;
        st_next.meta = din;
        st_next.sync = st_reg.meta;
        st_next.prev = st_reg.sync;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // Edges compare successive synchronised samples
    assign level = st_reg.sync;
    assign rise  = st_reg.sync & ~st_reg.prev;
    assign fall  = ~st_reg.sync & st_reg.prev;
endmodule // input_sync_edge

//--- rtl/access_arbiter.sv
module access_arbiter (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic panel_lock,
    input  wire logic panel_jog_start,
    input  wire logic panel_tune_start,
    input  wire logic panel_release,
    input  wire logic sw_take,
    input  wire logic sw_release,
    output logic      panel_owns,
    output logic      sw_owns,
    output logic      panel_start_ok
);
    typedef struct packed {
        logic panel;
        logic sw;
    } own_s;

    own_s st_reg;
    own_s st_next;
    logic start_req;

    always_comb begin
        start_req      = panel_jog_start | panel_tune_start;
        panel_start_ok = start_req & ~panel_lock & ~st_reg.sw;
        st_next        = st_reg;
        if (panel_start_ok) begin
            st_next.panel = 1'b1;
        end else if (panel_release) begin
            st_next.panel = 1'b0;
        end
        if (sw_take && !st_reg.panel && !panel_start_ok) begin
            st_next.sw = 1'b1;
        end else if (sw_release) begin
            st_next.sw = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign panel_owns = st_reg.panel;
    assign sw_owns    = st_reg.sw;
endmodule // access_arbiter

//--- rtl/drive_state_machine.sv
`include "drive_state_map.svh"

// Behaviour
// - Report state as number 1..9; state 1 while electronics initialise.
// - Leave state 1 for state 2 when initialisation finished.
// - State 2 goes to state 3 once first commissioning is complete.
// - State 3 to 4 on encoder ok, bus voltage present or speed below 1000.
// - Any single listed condition is enough to fire the 3 to 4 or 4 to 3 transition.
// - Rising enable edge in state 4 moves to state 5.
// - Enable still high: 5 to 6, amplifier on, checks run, brake released.
// - State 4 falls to 3 on bus undervoltage or speed above 1000.
// - Enable falling in state 6 goes to 3, amplifier off at once.
// - Enable falling in 5 or 7 goes to 3; amplifier off despite quick stop.
// - Class 1 error in state 6 quick stops and enters state 7.
// - Class 2, 3 or 4 error sends any state other than 9 into state 8.
// - Class 2 reaction: quick stop, close brake, then amplifier off; with amplifier already off, 8 then 9 at once.
// - Class 3, 4 or power removal: amplifier off at once, 8 then 9.
// - Finished error reaction moves state 8 to state 9.
// - Cause removed then fault clear in state 9 clears error, goes to 3.
// - Fault clear in state 7 returns to 6 and resumes the mode.
// - Rising fault-clear edge clears fault and erases stored error.
// - State 6 with halt holds motor, amplifier on; else runs mode.
// - State 5: motor unpowered, amplifier ready, no mode running.
// - Panel jog or tuning takes exclusive control; software commands rejected.
// - Lock value 1 refuses panel parameters, jog, tuning and fault clear.
// - Hardware halt, fault clear and enable always act, whoever has control.
// - No-fault in 4,5,6; brake release in 6,7 and during class 2 quick stop in 8; active in 6 only.
module drive_state_machine
    import drive_state_pkg::*;
#(
    parameter int BRAKE_DELAY = `BRAKE_DELAY_CYCLES
) (
    input  wire logic        REF_CLK,
    input  wire logic        RESETN,
    input  wire logic        ENABLE,
    input  wire logic        FAULT_RESET,
    input  wire logic        HALT,
    input  wire logic        INIT_DONE,
    input  wire logic        COMMISSIONED,
    input  wire logic        ENCODER_OK,
    input  wire logic        DC_BUS_OK,
    input  wire logic        DC_BUS_UNDERVOLT,
    input  wire logic [15:0] SPEED_RPM,
    input  wire logic        ERR_CLASS1,
    input  wire logic        ERR_CLASS2,
    input  wire logic        ERR_CLASS34,
    input  wire logic        POWER_REMOVED,
    input  wire logic        QSTOP_DONE,
    input  wire logic        PANEL_JOG_START,
    input  wire logic        PANEL_TUNE_START,
    input  wire logic        PANEL_RELEASE,
    input  wire logic        PANEL_PARAM_REQ,
    input  wire logic        PANEL_FAULT_CLEAR,
    input  wire logic        SW_TAKE,
    input  wire logic        SW_RELEASE,
    input  wire logic        SW_CMD_REQ,
    input  wire logic        PARAM_WR,
    input  wire logic        PARAM_RD,
    input  wire logic [15:0] PARAM_ADDR,
    input  wire logic [15:0] PARAM_WDATA,
    output logic      [15:0] PARAM_RDATA,
    output logic             PARAM_ACK,
    output logic             PARAM_ERR,
    output logic      [3:0]  STATE_NUM,
    output logic             NO_FAULT,
    output logic             BRAKE_RELEASE,
    output logic             ACTIVE,
    output logic             AMP_ON,
    output logic             QUICK_STOP,
    output logic             MODE_RUN,
    output logic             HOLD_STILL,
    output logic             PHASE_CHECK,
    output logic      [2:0]  ERROR_CODE,
    output logic             PANEL_OWNS,
    output logic             SW_OWNS,
    output logic             PANEL_ACCEPT,
    output logic             PANEL_REJECT,
    output logic             SW_REJECT
);

    typedef struct packed {
        op_state_e   state;
        react_e      react;
        logic [15:0] brake_cnt;
        err_class_t  err;
        logic [15:0] lock;
        logic [15:0] rdata;
        logic        ack;
        logic        perr;
        logic [3:0]  num;
        logic        no_fault;
        logic        brake_rel;
        logic        active;
        logic        amp;
        logic        qstop;
        logic        mode_run;
        logic        hold;
        logic        phase_chk;
        logic        p_owns;
        logic        s_owns;
        logic        p_acc;
        logic        p_rej;
        logic        s_rej;
    } core_s;

    core_s st_reg;
    core_s st_next;

    logic [2:0] pin_level;
    logic [2:0] pin_rise;
    logic [2:0] pin_fall;
    logic       en_lvl;
    logic       en_rise;
    logic       en_fall;
    logic       fr_rise;
    logic       halt_lvl;
    logic       panel_lock;
    logic       panel_owns;
    logic       sw_owns;
    logic       panel_start_ok;
    logic       fault_clear;
    logic       hard_err;
    logic       cause_gone;
    logic       speed_low;
    logic       speed_high;

    function automatic logic [3:0] state_num(input op_state_e s);
        case (s)
            ST_START:       state_num = `ST_NUM_START;
            ST_NOT_READY:   state_num = `ST_NUM_NOT_READY;
            ST_DISABLED:    state_num = `ST_NUM_DISABLED;
            ST_READY:       state_num = `ST_NUM_READY;
            ST_SWITCHED_ON: state_num = `ST_NUM_SWITCHED_ON;
            ST_OP_ENABLE:   state_num = `ST_NUM_OP_ENABLE;
            ST_QUICK_STOP:  state_num = `ST_NUM_QUICK_STOP;
            ST_FAULT_REACT: state_num = `ST_NUM_FAULT_REACT;
            ST_FAULT:       state_num = `ST_NUM_FAULT;
            default:        state_num = `ST_NUM_START;
        endcase
    endfunction

    // Hardware pins pass two flip-flops before use
    input_sync_edge #(
        .W (3)
    ) u_pins (
        .clk   (REF_CLK),
        .rst_n (RESETN),
        .din   ({HALT, FAULT_RESET, ENABLE}),
        .level (pin_level),
        .rise  (pin_rise),
        .fall  (pin_fall)
    );

    access_arbiter u_access (
        .clk              (REF_CLK),
        .rst_n            (RESETN),
        .panel_lock       (panel_lock),
        .panel_jog_start  (PANEL_JOG_START),
        .panel_tune_start (PANEL_TUNE_START),
        .panel_release    (PANEL_RELEASE),
        .sw_take          (SW_TAKE),
        .sw_release       (SW_RELEASE),
        .panel_owns       (panel_owns),
        .sw_owns          (sw_owns),
        .panel_start_ok   (panel_start_ok)
    );

    always_comb begin
        en_lvl      = pin_level[0];
        en_rise     = pin_rise[0];
        en_fall     = pin_fall[0];
        fr_rise     = pin_rise[1];
        halt_lvl    = pin_level[2];
        panel_lock  = (st_reg.lock == `PANEL_LOCK_ON);
        // Hardware fault clear is never gated by the access owner
        fault_clear = fr_rise | (PANEL_FAULT_CLEAR & ~panel_lock & ~sw_owns);
        hard_err    = ERR_CLASS34 | POWER_REMOVED;
        cause_gone  = ~ERR_CLASS1 & ~ERR_CLASS2 & ~hard_err;
        speed_low   = (SPEED_RPM < `SPEED_LIMIT_RPM);
        speed_high  = (SPEED_RPM > `SPEED_LIMIT_RPM);
    end

    always_comb begin
        st_next           = st_reg;
        st_next.ack       = 1'b0;
        st_next.perr      = 1'b0;
        st_next.p_acc     = 1'b0;
        st_next.p_rej     = 1'b0;
        st_next.s_rej     = 1'b0;
        st_next.phase_chk = 1'b0;
        st_next.p_owns    = panel_owns;
        st_next.s_owns    = sw_owns;

        // Parameter channel from the commissioning software
        if (PARAM_WR || PARAM_RD) begin
            st_next.ack = 1'b1;
            if (PARAM_ADDR != `PANEL_LOCK_ADDR) begin
                st_next.perr = 1'b1;
            end else if (PARAM_WR && panel_owns) begin
                st_next.perr = 1'b1;
            end else if (PARAM_WR) begin
                if (PARAM_WDATA == `PANEL_LOCK_OFF || PARAM_WDATA == `PANEL_LOCK_ON) begin
                    st_next.lock = PARAM_WDATA;
                end else begin
                    st_next.perr = 1'b1;
                end
            end else begin
                st_next.rdata = st_reg.lock;
            end
        end

        // Panel requests and software command filtering
        if (PANEL_PARAM_REQ || PANEL_FAULT_CLEAR) begin
            if (panel_lock || sw_owns) begin
                st_next.p_rej = 1'b1;
            end else begin
                st_next.p_acc = 1'b1;
            end
        end
        if ((PANEL_JOG_START || PANEL_TUNE_START) && !panel_start_ok) begin
            st_next.p_rej = 1'b1;
        end
        if (SW_CMD_REQ && panel_owns) begin
            st_next.s_rej = 1'b1;
        end

        // Stored error: a new error wins over a clear in the same cycle
        if (fault_clear) begin
            st_next.err = `ERR_NONE;
        end
        if (POWER_REMOVED) begin
            st_next.err = `ERR_POWER_REMOVED;
        end else if (ERR_CLASS34) begin
            st_next.err = `ERR_CLASS_34;
        end else if (ERR_CLASS2) begin
            st_next.err = `ERR_CLASS_2;
        end else if (ERR_CLASS1 && st_reg.state == ST_OP_ENABLE) begin
            st_next.err = `ERR_CLASS_1;
        end

        // One transition per cycle; error entry checked first
        if (hard_err && st_reg.state != ST_FAULT && st_reg.react != RX_OFF) begin
            st_next.state = ST_FAULT_REACT;
            st_next.react = RX_OFF;
            st_next.amp   = 1'b0;
            st_next.qstop = 1'b0;
        end else if (ERR_CLASS2 && st_reg.state != ST_FAULT_REACT
                     && st_reg.state != ST_FAULT) begin
            st_next.state = ST_FAULT_REACT;
            st_next.react = st_reg.amp ? RX_STOP : RX_OFF;
            st_next.qstop = st_reg.amp;
        end else begin
            case (st_reg.state)
                ST_START: begin
                    if (INIT_DONE) begin
                        st_next.state = ST_NOT_READY;
                    end
                end
                ST_NOT_READY: begin
                    if (COMMISSIONED) begin
                        st_next.state = ST_DISABLED;
                    end
                end
                ST_DISABLED: begin
                    if (ENCODER_OK || DC_BUS_OK || speed_low) begin
                        st_next.state = ST_READY;
                    end
                end
                ST_READY: begin
                    if (DC_BUS_UNDERVOLT || speed_high) begin
                        st_next.state = ST_DISABLED;
                    end else if (en_rise) begin
                        st_next.state = ST_SWITCHED_ON;
                    end
                end
                ST_SWITCHED_ON: begin
                    if (en_fall || !en_lvl) begin
                        st_next.state = ST_DISABLED;
                    end else begin
                        st_next.state     = ST_OP_ENABLE;
                        st_next.amp       = 1'b1;
                        st_next.phase_chk = 1'b1;
                    end
                end
                ST_OP_ENABLE: begin
                    if (en_fall) begin
                        st_next.state = ST_DISABLED;
                        st_next.amp   = 1'b0;
                    end else if (ERR_CLASS1) begin
                        st_next.state = ST_QUICK_STOP;
                        st_next.qstop = 1'b1;
                    end
                end
                ST_QUICK_STOP: begin
                    if (en_fall) begin
                        st_next.state = ST_DISABLED;
                        st_next.amp   = 1'b0;
                        st_next.qstop = 1'b0;
                    end else if (fault_clear) begin
                        st_next.state = ST_OP_ENABLE;
                        st_next.qstop = 1'b0;
                    end
                end
                ST_FAULT_REACT: begin
                    case (st_reg.react)
                        RX_STOP: begin
                            if (QSTOP_DONE) begin
                                st_next.react     = RX_BRAKE;
                                st_next.qstop     = 1'b0;
                                st_next.brake_cnt = 16'(BRAKE_DELAY);
                            end
                        end
                        RX_BRAKE: begin
                            if (st_reg.brake_cnt <= 16'h0001) begin
                                st_next.react = RX_OFF;
                                st_next.amp   = 1'b0;
                            end else begin
                                st_next.brake_cnt = st_reg.brake_cnt - 16'h0001;
                            end
                        end
                        RX_OFF: begin
                            st_next.state = ST_FAULT;
                            st_next.react = RX_IDLE;
                            st_next.amp   = 1'b0;
                        end
                        default: begin
                            st_next.react = RX_OFF;
                        end
                    endcase
                end
                ST_FAULT: begin
                    if (fault_clear && cause_gone) begin
                        st_next.state = ST_DISABLED;
                    end
                end
                default: begin
                    st_next.state = ST_START;
                end
            endcase
        end

        // Amplifier off wherever the next state leaves it unpowered
        if (st_next.state != ST_OP_ENABLE && st_next.state != ST_QUICK_STOP
            && st_next.state != ST_FAULT_REACT) begin
            st_next.amp   = 1'b0;
            st_next.qstop = 1'b0;
        end

        // Registered status outputs follow the next state
        st_next.num       = state_num(st_next.state);
        st_next.no_fault  = (st_next.state == ST_READY) || (st_next.state == ST_SWITCHED_ON)
                            || (st_next.state == ST_OP_ENABLE);
        st_next.brake_rel = ((st_next.state == ST_OP_ENABLE) || (st_next.state == ST_QUICK_STOP)
                            || (st_next.state == ST_FAULT_REACT))
                            && !(st_next.react == RX_BRAKE || st_next.react == RX_OFF);
        st_next.active    = (st_next.state == ST_OP_ENABLE);
        st_next.mode_run  = (st_next.state == ST_OP_ENABLE) && !halt_lvl;
        st_next.hold      = (st_next.state == ST_OP_ENABLE) && halt_lvl;
    end

    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            st_reg       <= '0;
            st_reg.state <= ST_START;
            st_reg.react <= RX_IDLE;
            st_reg.lock  <= `PANEL_LOCK_RESET;
            st_reg.num   <= `ST_NUM_START;
        end else begin
            st_reg <= st_next;
        end
    end

    assign PARAM_RDATA   = st_reg.rdata;
    assign PARAM_ACK     = st_reg.ack;
    assign PARAM_ERR     = st_reg.perr;
    assign STATE_NUM     = st_reg.num;
    assign NO_FAULT      = st_reg.no_fault;
    assign BRAKE_RELEASE = st_reg.brake_rel;
    assign ACTIVE        = st_reg.active;
    assign AMP_ON        = st_reg.amp;
    assign QUICK_STOP    = st_reg.qstop;
    assign MODE_RUN      = st_reg.mode_run;
    assign HOLD_STILL    = st_reg.hold;
    assign PHASE_CHECK   = st_reg.phase_chk;
    assign ERROR_CODE    = st_reg.err;
    assign PANEL_OWNS    = st_reg.p_owns;
    assign SW_OWNS       = st_reg.s_owns;
    assign PANEL_ACCEPT  = st_reg.p_acc;
    assign PANEL_REJECT  = st_reg.p_rej;
    assign SW_REJECT     = st_reg.s_rej;
endmodule // drive_state_machine

//--- testbench/drive_state_machine_monitor.sv
module drive_state_machine_monitor #(
    parameter int BRAKE_DELAY = 16
) (
    input wire logic        REF_CLK,
    input wire logic        RESETN,
    input wire logic        INIT_DONE,
    input wire logic        ERR_CLASS1,
    input wire logic        ERR_CLASS2,
    input wire logic        ERR_CLASS34,
    input wire logic        POWER_REMOVED,
    input wire logic        PARAM_WR,
    input wire logic        PARAM_RD,
    input wire logic [15:0] PARAM_ADDR,
    input wire logic        PARAM_ERR,
    input wire logic [3:0]  STATE_NUM,
    input wire logic        NO_FAULT,
    input wire logic        BRAKE_RELEASE,
    input wire logic        ACTIVE,
    input wire logic        AMP_ON,
    input wire logic        QUICK_STOP,
    input wire logic        PHASE_CHECK
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RESETN);
    localparam int BRAKE_MAX = (BRAKE_DELAY < 1) ? 1 : BRAKE_DELAY;
    logic hard_err;
    assign hard_err = ERR_CLASS34 || POWER_REMOVED;
    sequence s_c2_enter;
        STATE_NUM == 4'h8 && QUICK_STOP;
    endsequence
    sequence s_brake_off;
        !BRAKE_RELEASE && AMP_ON ##[1:BRAKE_MAX] !AMP_ON;
    endsequence
    AST_NO_FAULT: assert property (NO_FAULT == (STATE_NUM inside {4'h4, 4'h5, 4'h6}))
        else $error("no-fault output wrong for state");
    AST_ACTIVE: assert property (ACTIVE == (STATE_NUM == 4'h6))
        else $error("active output wrong for state");
    AST_BRAKE: assert property (BRAKE_RELEASE |-> STATE_NUM inside {4'h6, 4'h7, 4'h8})
        else $error("brake released in wrong state");
    AST_INIT: assert property (STATE_NUM == 4'h1 && INIT_DONE && !ERR_CLASS2 && !hard_err
        |=> STATE_NUM == 4'h2) else $error("no move from start");
    AST_HARD: assert property (hard_err && !(STATE_NUM inside {4'h8, 4'h9})
        |=> STATE_NUM == 4'h8 && !AMP_ON ##1 STATE_NUM == 4'h9) else $error("hard fault path");
    AST_CLASS1: assert property (STATE_NUM == 4'h6 && ERR_CLASS1 && !ERR_CLASS2 && !hard_err
        |=> STATE_NUM == 4'h7 && QUICK_STOP && AMP_ON) else $error("class 1 stop missing");
    AST_CLASS2: assert property (STATE_NUM == 4'h6 && ERR_CLASS2 && !hard_err |=> s_c2_enter)
        else $error("class 2 reaction missing");
    AST_BRAKE_SEQ: assert property (STATE_NUM == 4'h8 && $fell(QUICK_STOP)
        && !$past(hard_err) |-> s_brake_off) else $error("brake close then amplifier off order");
    AST_PHASE: assert property (PHASE_CHECK |-> STATE_NUM == 4'h6 && AMP_ON && BRAKE_RELEASE
        && $past(STATE_NUM) == 4'h5) else $error("phase check outside entry to 6");
    AST_PARAM: assert property ((PARAM_WR || PARAM_RD) && PARAM_ADDR != 16'h3A02
        |=> PARAM_ERR) else $error("unmapped access not refused");
endmodule // drive_state_machine_monitor

bind drive_state_machine drive_state_machine_monitor #(.BRAKE_DELAY(BRAKE_DELAY)) u_mon (.*);

//--- testbench/machine_ctrl_model.sv
module machine_ctrl_model (
    input  wire logic clk,
    input  wire logic en_cmd,
    input  wire logic clr_cmd,
    output logic      ENABLE,
    output logic      FAULT_RESET
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] clr_cnt = 3'h0;
    assign ENABLE = en_cmd;
    assign FAULT_RESET = (clr_cnt != 3'h0);
    always @(posedge clk) begin
        if (clr_cmd) begin
            clr_cnt <= 3'h4;
        end else if (clr_cnt != 3'h0) begin
            clr_cnt <= clr_cnt - 3'h1;
        end
    end
endmodule // machine_ctrl_model

//--- testbench/drive_state_machine_test.sv
module drive_state_machine_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic REF_CLK = 1'b0, RESETN = 1'b0, HALT = 1'b0, INIT_DONE = 1'b0, COMMISSIONED = 1'b0;
    logic ENCODER_OK = 1'b0, DC_BUS_OK = 1'b0, DC_BUS_UNDERVOLT = 1'b0, ERR_CLASS1 = 1'b0;
    logic ERR_CLASS2 = 1'b0, ERR_CLASS34 = 1'b0, POWER_REMOVED = 1'b0, QSTOP_DONE = 1'b0;
    logic PANEL_JOG_START = 1'b0, PANEL_TUNE_START = 1'b0, PANEL_RELEASE = 1'b0;
    logic PANEL_PARAM_REQ = 1'b0, PANEL_FAULT_CLEAR = 1'b0, SW_TAKE = 1'b0, SW_RELEASE = 1'b0;
    logic SW_CMD_REQ = 1'b0, PARAM_WR = 1'b0, PARAM_RD = 1'b0, en_cmd = 1'b0, clr_cmd = 1'b0;
    logic [15:0] SPEED_RPM = 16'h03E8, PARAM_ADDR = 16'h0000, PARAM_WDATA = 16'h0000;
    logic [15:0] PARAM_RDATA;
    logic [3:0]  STATE_NUM;
    logic [2:0]  ERROR_CODE;
    logic ENABLE, FAULT_RESET, PARAM_ACK, PARAM_ERR, NO_FAULT, BRAKE_RELEASE, ACTIVE, AMP_ON;
    logic QUICK_STOP, MODE_RUN, HOLD_STILL, PHASE_CHECK, PANEL_OWNS, SW_OWNS, PANEL_ACCEPT;
    logic PANEL_REJECT, SW_REJECT, seen;
    int errors = 0;
    int n_compared = 0;
    always #25 REF_CLK = ~REF_CLK;
    drive_state_machine #(.BRAKE_DELAY(2)) u_dut (.*);
    machine_ctrl_model u_ctrl (.clk(REF_CLK), .en_cmd(en_cmd), .clr_cmd(clr_cmd),
        .ENABLE(ENABLE), .FAULT_RESET(FAULT_RESET));
    task automatic results();
        if (errors == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge REF_CLK);
    endtask
    task automatic wst(input logic [3:0] s);
        for (int i = 0; i < 60 && STATE_NUM !== s; i++) @(negedge REF_CLK);
        chk(STATE_NUM, s, "state");
        if (STATE_NUM !== s) results();
    endtask
    task automatic fclr(input logic [3:0] s);
        clr_cmd = 1'b1;
        cyc(1);
        clr_cmd = 1'b0;
        wst(s);
    endtask
    task automatic prm(input logic w, input logic [15:0] a, input logic [15:0] d, input logic e);
        PARAM_WR = w;
        PARAM_RD = !w;
        PARAM_ADDR = a;
        PARAM_WDATA = d;
        cyc(1);
        chk(PARAM_ERR, e, "param refusal");
        chk(PARAM_ACK, 1'b1, "param ack");
        PARAM_WR = 1'b0;
        PARAM_RD = 1'b0;
        cyc(1);
    endtask
    initial begin
        cyc(12);
        chk(STATE_NUM, 4'h1, "start state");
        RESETN = 1'b1;
        cyc(2);
        INIT_DONE = 1'b1;
        wst(4'h2);
        COMMISSIONED = 1'b1;
        wst(4'h3);
        cyc(4);
        chk(STATE_NUM, 4'h3, "speed at limit");
        SPEED_RPM = 16'h03E7;
        wst(4'h4);
        SPEED_RPM = 16'h03E9;
        wst(4'h3);
        SPEED_RPM = 16'h03E8;
        DC_BUS_OK = 1'b1;
        wst(4'h4);
        DC_BUS_UNDERVOLT = 1'b1;
        wst(4'h3);
        DC_BUS_UNDERVOLT = 1'b0;
        wst(4'h4);
        en_cmd = 1'b1;
        wst(4'h6);
        chk(AMP_ON, 1'b1, "amplifier on");
        HALT = 1'b1;
        cyc(5);
        chk({HOLD_STILL, MODE_RUN}, 2'b10, "halt hold");
        HALT = 1'b0;
        ERR_CLASS1 = 1'b1;
        wst(4'h7);
        ERR_CLASS1 = 1'b0;
        fclr(4'h6);
        chk(QUICK_STOP, 1'b0, "stop ended");
        en_cmd = 1'b0;
        wst(4'h3);
        chk(AMP_ON, 1'b0, "amplifier off");
        en_cmd = 1'b1;
        wst(4'h6);
        ERR_CLASS2 = 1'b1;
        wst(4'h8);
        ERR_CLASS2 = 1'b0;
        QSTOP_DONE = 1'b1;
        wst(4'h9);
        QSTOP_DONE = 1'b0;
        chk(ERROR_CODE, 3'h2, "stored class 2");
        en_cmd = 1'b0;
        fclr(4'h3);
        chk(ERROR_CODE, 3'h0, "error erased");
        prm(1'b1, 16'h3A02, 16'h0001, 1'b0);
        prm(1'b0, 16'h3A02, 16'h0000, 1'b0);
        chk(PARAM_RDATA, 16'h0001, "lock readback");
        prm(1'b1, 16'h3A02, 16'h0002, 1'b1);
        prm(1'b0, 16'h3A03, 16'h0000, 1'b1);
        POWER_REMOVED = 1'b1;
        wst(4'h9);
        POWER_REMOVED = 1'b0;
        PANEL_FAULT_CLEAR = 1'b1;
        cyc(1);
        chk(PANEL_REJECT, 1'b1, "panel clear refused");
        PANEL_FAULT_CLEAR = 1'b0;
        cyc(4);
        chk(STATE_NUM, 4'h9, "locked panel clear");
        fclr(4'h4);
        prm(1'b1, 16'h3A02, 16'h0000, 1'b0);
        ERR_CLASS34 = 1'b1;
        wst(4'h9);
        chk(ERROR_CODE, 3'h3, "stored class 3");
        ERR_CLASS34 = 1'b0;
        PANEL_FAULT_CLEAR = 1'b1;
        cyc(1);
        chk(PANEL_ACCEPT, 1'b1, "panel clear accepted");
        PANEL_FAULT_CLEAR = 1'b0;
        wst(4'h4);
        PANEL_JOG_START = 1'b1;
        cyc(1);
        PANEL_JOG_START = 1'b0;
        cyc(3);
        chk(PANEL_OWNS, 1'b1, "panel owns");
        SW_CMD_REQ = 1'b1;
        cyc(1);
        SW_CMD_REQ = 1'b0;
        seen = SW_REJECT;
        cyc(1);
        chk(seen | SW_REJECT, 1'b1, "software refused");
        prm(1'b1, 16'h3A02, 16'h0001, 1'b1);
        results();
    end
endmodule // drive_state_machine_test
